//--- include/flash_if_defines.vh
// constants for the sector flash host-side pin interface
`ifndef FLASH_IF_DEFINES_VH
`define FLASH_IF_DEFINES_VH
`define CMD_READ_SERIAL1 8'h00
`define CMD_READ_SERIAL2 8'hF0
`define CMD_PROGRAM1 8'h10
`define CMD_PROGRAM2 8'h1F
`define CMD_PROGRAM3 8'h0F
`define CMD_PROGRAM4 8'h11
`define CMD_ERASE 8'h20
`define CMD_PROG_CONFIRM 8'h40
`define CMD_ERASE_CONFIRM 8'hB0
`define CMD_RESET 8'hFF
`define CMD_CLEAR_STATUS 8'h50
`define SECTOR_MAIN_BYTES 2048
`define SECTOR_EXTRA_BYTES 64
`define SECTOR_BYTES 2112
`define COL_WIDTH 12
`define FIFO_DEPTH 32
`define FIFO_AW 5
`define PROG_TIME_US 3000
`define ERASE_TIME_US 1500
`define CLK_MHZ 50
`define PROG_CYCLES (`PROG_TIME_US * `CLK_MHZ)
`define ERASE_CYCLES (`ERASE_TIME_US * `CLK_MHZ)
`define STATUS_READY_BIT 7
`define STATUS_FAIL_BIT 5
`endif

//--- design/byte_fifo.v
// parameterised valid/ready fifo used in the data path
`timescale 1ns/100ps
`default_nettype none
module byte_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 32,
    parameter AW = 5
) (
    input wire clk,
    input wire srst,
    input wire flush,
    input wire [WIDTH-1:0] in_data,
    input wire in_valid,
    output wire in_ready,
    output wire [WIDTH-1:0] out_data,
    output wire out_valid,
    input wire out_ready
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW:0] wr_reg;
    reg [AW:0] rd_reg;
    wire full = (wr_reg[AW] != rd_reg[AW]) && (wr_reg[AW-1:0] == rd_reg[AW-1:0]);
    wire empty = (wr_reg == rd_reg);
    assign in_ready = !full;
    assign out_valid = !empty;
    assign out_data = mem[rd_reg[AW-1:0]];
    always @(posedge clk) begin
        if (in_valid && !full) begin
            mem[wr_reg[AW-1:0]] <= in_data;
        end
    end
    always @(posedge clk) begin
        if (srst || flush) begin
            wr_reg <= {(AW+1){1'b0}};
            rd_reg <= {(AW+1){1'b0}};
        end else begin
            if (in_valid && !full) begin
                wr_reg <= wr_reg + 1'b1;
            end
            if (out_ready && !empty) begin
                rd_reg <= rd_reg + 1'b1;
            end
        end
    end
endmodule // byte_fifo
`default_nettype wire

//--- design/sector_flash_host_interface.v
// device-side pin protocol, mode control and sector engine of the flash
`timescale 1ns/100ps
`default_nettype none
`include "flash_if_defines.vh"
// Summary of operation
// - read ends in standby on chip select rise
// - chip select rise ignored while busy
// - bus driven only while output enable low
// - command and address taken on write rise
// - data moves one byte per clock rise
// - select low means command/data, high address
// - busy pulled low after 40H or B0H
// - busy released when operation finishes
// - status read mode after power-up
// - operations start only after full command sequence
// - one shared byte bus both directions
// - whole sector 2048+64 through data register
module sector_flash_host_interface #(
    parameter PROG_CYCLES = `PROG_CYCLES,
    parameter ERASE_CYCLES = `ERASE_CYCLES
) (
    // system
    input wire CLOCK,
    input wire SRST,
    // control pins
    input wire CHIP_SELECT_N,
    input wire OUTPUT_ENABLE_N,
    input wire WRITE_STROBE_N,
    input wire COMMAND_DATA_SELECT,
    input wire SERIAL_DATA_CLOCK,
    input wire POWER_GUARD_HOLD,
    // byte bus
    input wire [7:0] BYTE_BUS_IN,
    output reg [7:0] BYTE_BUS_OUT,
    output reg BYTE_BUS_OE,
    // ready/busy open drain
    output reg READY_BUSY_OUT,
    output reg READY_BUSY_OE,
    // state
    output reg STANDBY,
    output reg DEEP_STANDBY
);
    localparam ST_STATUS = 3'd0;
    localparam ST_CMD = 3'd1;
    localparam ST_ADDR = 3'd2;
    localparam ST_LOAD = 3'd3;
    localparam ST_BUSY = 3'd4;
    localparam ST_READ = 3'd5;

    // two-flop synchronisers for every pin, per bit
    wire [13:0] pins_raw = {BYTE_BUS_IN, CHIP_SELECT_N, OUTPUT_ENABLE_N, WRITE_STROBE_N,
                            COMMAND_DATA_SELECT, SERIAL_DATA_CLOCK, POWER_GUARD_HOLD};
    reg [13:0] meta_reg;
    reg [13:0] sync_reg;
    reg [13:0] prev_reg;
    genvar gi;
    generate
        for (gi = 0; gi < 14; gi = gi + 1) begin : g_sync
            always @(posedge CLOCK) begin
                if (SRST) begin
                    meta_reg[gi] <= 1'b1;
                    sync_reg[gi] <= 1'b1;
                    prev_reg[gi] <= 1'b1;
                end else begin
                    meta_reg[gi] <= pins_raw[gi];
                    sync_reg[gi] <= meta_reg[gi];
                    prev_reg[gi] <= sync_reg[gi];
                end
            end
        end
    endgenerate
    wire ce_n = sync_reg[5];
    wire oe_n = sync_reg[4];
    wire sel_s = sync_reg[2];
    wire guard = sync_reg[0];
    wire ce_rise = sync_reg[5] && !prev_reg[5];
    wire we_rise = sync_reg[3] && !prev_reg[3] && !ce_n;
    wire sc_rise = sync_reg[1] && !prev_reg[1] && !ce_n;
    // bus is sampled one cycle late, so latch the byte held before the strobe rose
    wire [7:0] bus_held = prev_reg[13:6];

    reg [2:0] state_reg, state_next;
    reg [7:0] cmd_reg, cmd_next;
    reg [2:0] addr_cnt_reg, addr_cnt_next;
    reg [15:0] sector_reg, sector_next;
    reg [11:0] col_reg, col_next;
    reg [11:0] ptr_reg, ptr_next;
    reg [22:0] timer_reg, timer_next;
    reg erase_reg, erase_next;
    reg fail_reg, fail_next;
    reg out_status_reg, out_status_next;
    reg [7:0] sector_ram [0:`SECTOR_BYTES-1];

    // incoming programme data passes the fifo before reaching the data register
    wire fifo_in_valid = (state_reg == ST_LOAD) && sc_rise && !sel_s;
    wire fifo_in_ready;
    wire [7:0] fifo_out_data;
    wire fifo_out_valid;
    wire fifo_drain = fifo_out_valid && (ptr_reg < `SECTOR_BYTES);
    wire fifo_flush = (state_reg == ST_STATUS);
    byte_fifo #(.WIDTH(8), .DEPTH(`FIFO_DEPTH), .AW(`FIFO_AW)) u_fifo (
        .clk(CLOCK),
        .srst(SRST),
        .flush(fifo_flush),
        .in_data(bus_held),
        .in_valid(fifo_in_valid),
        .in_ready(fifo_in_ready),
        .out_data(fifo_out_data),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_drain)
    );

    always @(posedge CLOCK) begin
        if (fifo_drain) begin
            sector_ram[ptr_reg] <= fifo_out_data;
        end
    end
    wire [7:0] ram_byte = sector_ram[col_reg];
    wire [7:0] status_byte = {(state_reg != ST_BUSY), 1'b0, fail_reg, 5'h00};
    wire prog_cmd = (cmd_reg == `CMD_PROGRAM1) || (cmd_reg == `CMD_PROGRAM2) ||
                    (cmd_reg == `CMD_PROGRAM3) || (cmd_reg == `CMD_PROGRAM4);
    wire read_cmd = (cmd_reg == `CMD_READ_SERIAL1) || (cmd_reg == `CMD_READ_SERIAL2);

    always @* begin
        state_next = state_reg;
        cmd_next = cmd_reg;
        addr_cnt_next = addr_cnt_reg;
        sector_next = sector_reg;
        col_next = col_reg;
        ptr_next = ptr_reg;
        timer_next = timer_reg;
        erase_next = erase_reg;
        fail_next = fail_reg;
        out_status_next = out_status_reg;
        if (fifo_drain) begin
            ptr_next = ptr_reg + 12'h001;
        end
        case (state_reg)
            ST_STATUS, ST_READ: begin
                if (ce_rise && state_reg == ST_READ) begin
                    state_next = ST_STATUS;
                    out_status_next = 1'b1;
                end
                if (we_rise && !sel_s) begin
                    if (bus_held == `CMD_CLEAR_STATUS) begin
                        fail_next = 1'b0;
                    end else if (bus_held == `CMD_RESET) begin
                        state_next = ST_STATUS;
                        out_status_next = 1'b1;
                    end else begin
                        cmd_next = bus_held;
                        addr_cnt_next = 3'd0;
                        col_next = 12'h000;
                        ptr_next = 12'h000;
                        state_next = ST_ADDR;
                    end
                end
                if (state_reg == ST_READ && sc_rise) begin
                    col_next = (col_reg == `SECTOR_BYTES - 1) ? col_reg : col_reg + 12'h001;
                end
                // column bytes after the sector address choose the first byte sent out
                if (state_reg == ST_READ && we_rise && sel_s) begin
                    if (addr_cnt_reg == 3'd2) begin
                        col_next[7:0] = bus_held;
                        addr_cnt_next = 3'd3;
                    end else if (addr_cnt_reg == 3'd3) begin
                        col_next[11:8] = bus_held[3:0];
                        addr_cnt_next = 3'd4;
                    end
                end
            end
            ST_ADDR: begin
                if (we_rise && sel_s) begin
                    addr_cnt_next = addr_cnt_reg + 3'd1;
                    case (addr_cnt_reg)
                        3'd0: sector_next[7:0] = bus_held;
                        3'd1: sector_next[15:8] = bus_held;
                        3'd2: col_next[7:0] = bus_held;
                        3'd3: col_next[11:8] = bus_held[3:0];
                        default: addr_cnt_next = addr_cnt_reg;
                    endcase
                    if (read_cmd && addr_cnt_reg == 3'd1) begin
                        state_next = ST_READ;
                        out_status_next = 1'b0;
                    end
                    if (prog_cmd && addr_cnt_reg >= 3'd1) begin
                        state_next = ST_LOAD;
                    end
                end else if (we_rise && !sel_s) begin
                    if (read_cmd && addr_cnt_reg >= 3'd2) begin
                        state_next = ST_READ;
                        out_status_next = 1'b0;
                    end else if (cmd_reg == `CMD_ERASE && addr_cnt_reg >= 3'd2 &&
                                 bus_held == `CMD_ERASE_CONFIRM) begin
                        erase_next = 1'b1;
                        timer_next = ERASE_CYCLES[22:0];
                        state_next = ST_BUSY;
                    end else begin
                        state_next = ST_STATUS;
                        out_status_next = 1'b1;
                    end
                end
            end
            ST_LOAD: begin
                if (we_rise && !sel_s) begin
                    if (bus_held == `CMD_PROG_CONFIRM) begin
                        erase_next = 1'b0;
                        timer_next = PROG_CYCLES[22:0];
                        state_next = ST_BUSY;
                    end else begin
                        state_next = ST_STATUS;
                    end
                    out_status_next = 1'b1;
                end else if (we_rise && sel_s) begin
                    // column bytes place the data before any data clock, so no drain is lost
                    if (addr_cnt_reg == 3'd2) begin
                        ptr_next[7:0] = bus_held;
                        addr_cnt_next = 3'd3;
                    end else if (addr_cnt_reg == 3'd3) begin
                        ptr_next[11:8] = bus_held[3:0];
                        addr_cnt_next = 3'd4;
                    end
                end
            end
            ST_BUSY: begin
                // chip select edges are ignored here
                if (timer_reg == 23'd0) begin
                    state_next = ST_STATUS;
                end else begin
                    timer_next = timer_reg - 23'd1;
                end
            end
            default: state_next = ST_STATUS;
        endcase
        if (!guard) begin
            state_next = ST_STATUS;
            out_status_next = 1'b1;
            timer_next = 23'd0;
            if (state_reg == ST_BUSY) begin
                fail_next = 1'b1;
            end
        end
    end

    always @(posedge CLOCK) begin
        if (SRST) begin
            state_reg <= ST_STATUS;
            cmd_reg <= 8'hFF;
            addr_cnt_reg <= 3'd0;
            sector_reg <= 16'h0000;
            col_reg <= 12'h000;
            ptr_reg <= 12'h000;
            timer_reg <= 23'd0;
            erase_reg <= 1'b0;
            fail_reg <= 1'b0;
            out_status_reg <= 1'b1;
            BYTE_BUS_OUT <= 8'h00;
            BYTE_BUS_OE <= 1'b0;
            READY_BUSY_OUT <= 1'b0;
            READY_BUSY_OE <= 1'b0;
            STANDBY <= 1'b1;
            DEEP_STANDBY <= 1'b0;
        end else begin
            state_reg <= state_next;
            cmd_reg <= cmd_next;
            addr_cnt_reg <= addr_cnt_next;
            sector_reg <= sector_next;
            col_reg <= col_next;
            ptr_reg <= ptr_next;
            timer_reg <= timer_next;
            erase_reg <= erase_next;
            fail_reg <= fail_next;
            out_status_reg <= out_status_next;
            // one shared bus, driven only for a read cycle
            BYTE_BUS_OE <= !ce_n && !oe_n && guard && state_reg != ST_LOAD
                           && state_reg != ST_ADDR;
            BYTE_BUS_OUT <= (out_status_reg || state_reg != ST_READ) ? status_byte
                            : ram_byte;
            READY_BUSY_OUT <= 1'b0;
            READY_BUSY_OE <= (state_next == ST_BUSY);
            STANDBY <= ce_n && state_reg != ST_BUSY;
            DEEP_STANDBY <= !guard;
        end
    end
endmodule // sector_flash_host_interface
`default_nettype wire

//--- test/flash_pin_monitor.sv
// assertion checker for the sector flash pin interface
`timescale 1ns/100ps
`default_nettype none
module flash_pin_monitor #(
    parameter PROG_CYCLES = 150000,
    parameter ERASE_CYCLES = 75000
) (
    // system
    input wire CLOCK,
    input wire SRST,
    // control pins
    input wire CHIP_SELECT_N,
    input wire OUTPUT_ENABLE_N,
    input wire WRITE_STROBE_N,
    input wire COMMAND_DATA_SELECT,
    input wire SERIAL_DATA_CLOCK,
    input wire POWER_GUARD_HOLD,
    // bus, ready/busy and state
    input wire [7:0] BYTE_BUS_IN,
    input wire [7:0] BYTE_BUS_OUT,
    input wire BYTE_BUS_OE,
    input wire READY_BUSY_OUT,
    input wire READY_BUSY_OE,
    input wire STANDBY,
    input wire DEEP_STANDBY
);
    logic [31:0] busy_cnt_reg;
    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (SRST);
    // span length is judged at the release, so count while busy is pulled
    always_ff @(posedge CLOCK) begin
        if (SRST || !READY_BUSY_OE) begin
            busy_cnt_reg <= 32'h0;
        end else begin
            busy_cnt_reg <= busy_cnt_reg + 32'h1;
        end
    end
    sequence s_read_held;
        (!CHIP_SELECT_N && !OUTPUT_ENABLE_N && WRITE_STROBE_N && POWER_GUARD_HOLD) [*8];
    endsequence
    sequence s_idle_held;
        (CHIP_SELECT_N && POWER_GUARD_HOLD && !READY_BUSY_OE) [*6];
    endsequence
    property p_bus_on;
        s_read_held |-> BYTE_BUS_OE;
    endproperty
    a_bus_on: assert property (p_bus_on) else $error("status not driven");
    property p_bus_off;
        $rose(OUTPUT_ENABLE_N) |-> ##[1:6] !BYTE_BUS_OE;
    endproperty
    a_bus_off: assert property (p_bus_off) else $error("bus kept driven");
    property p_confirm;
        $rose(READY_BUSY_OE) |-> !$past(COMMAND_DATA_SELECT, 3)
            && ($past(BYTE_BUS_IN, 3) inside {8'h40, 8'hB0});
    endproperty
    a_confirm: assert property (p_confirm) else $error("busy without confirm");
    property p_span;
        $fell(READY_BUSY_OE) |-> busy_cnt_reg inside
            {[ERASE_CYCLES:ERASE_CYCLES + 1], [PROG_CYCLES:PROG_CYCLES + 1]};
    endproperty
    a_span: assert property (p_span) else $error("busy span wrong");
    property p_standby_busy;
        READY_BUSY_OE && $past(READY_BUSY_OE) |-> !STANDBY;
    endproperty
    a_standby_busy: assert property (p_standby_busy) else $error("standby while busy");
    property p_standby_return;
        s_idle_held |-> STANDBY;
    endproperty
    a_standby_return: assert property (p_standby_return) else $error("no standby");
    property p_deep;
        (!POWER_GUARD_HOLD) [*6] |-> DEEP_STANDBY && !BYTE_BUS_OE;
    endproperty
    a_deep: assert property (p_deep) else $error("deep standby wrong");
    property p_open_drain;
        READY_BUSY_OE |-> !READY_BUSY_OUT;
    endproperty
    a_open_drain: assert property (p_open_drain) else $error("busy not low");
endmodule // flash_pin_monitor
bind sector_flash_host_interface flash_pin_monitor #(
    .PROG_CYCLES(PROG_CYCLES), .ERASE_CYCLES(ERASE_CYCLES)) i_mon (
    .CLOCK(CLOCK), .SRST(SRST), .CHIP_SELECT_N(CHIP_SELECT_N),
    .OUTPUT_ENABLE_N(OUTPUT_ENABLE_N), .WRITE_STROBE_N(WRITE_STROBE_N),
    .COMMAND_DATA_SELECT(COMMAND_DATA_SELECT), .SERIAL_DATA_CLOCK(SERIAL_DATA_CLOCK),
    .POWER_GUARD_HOLD(POWER_GUARD_HOLD), .BYTE_BUS_IN(BYTE_BUS_IN),
    .BYTE_BUS_OUT(BYTE_BUS_OUT), .BYTE_BUS_OE(BYTE_BUS_OE), .READY_BUSY_OUT(READY_BUSY_OUT),
    .READY_BUSY_OE(READY_BUSY_OE), .STANDBY(STANDBY), .DEEP_STANDBY(DEEP_STANDBY));
`default_nettype wire

//--- test/flash_host_model.sv
// flash controller model driving the pins of the sector flash
`timescale 1ns/100ps
`default_nettype none
module flash_host_model (
    // clock
    input wire logic clk,
    // pins toward the flash
    output logic cs_n,
    output logic oe_n,
    output logic we_n,
    output logic sel,
    output logic sclk,
    output logic guard,
    output logic [7:0] bus
);
    initial begin
        cs_n = 1'b1;
        oe_n = 1'b1;
        we_n = 1'b1;
        sel = 1'b0;
        sclk = 1'b0;
        guard = 1'b0;
        bus = 8'h00;
    end
    task automatic pins(input logic c, input logic o, input logic g);
        @(negedge clk);
        cs_n = c;
        oe_n = o;
        guard = g;
    endtask
    // k: 00 command, 01 address, 10 data on the 80 ns data clock pulse
    // the byte is held 8 clocks past the rise, then shows its inverse
    task automatic xfer(input logic [1:0] k, input logic [7:0] b);
        @(negedge clk);
        cs_n = 1'b0;
        sel = k[0];
        bus = b;
        we_n = k[1];
        repeat (4) @(negedge clk);
        we_n = 1'b1;
        sclk = k[1];
        repeat (4) @(negedge clk);
        sclk = 1'b0;
        repeat (4) @(negedge clk);
        bus = ~b;
    endtask
endmodule // flash_host_model
`default_nettype wire

//--- test/tb.sv
// self-checking bench for the sector flash pin interface
`timescale 1ns/100ps
`default_nettype none
module tb;
    localparam int PROG = 60;
    localparam int ERASE = 40;
    logic clock;
    logic srst;
    logic cs_n, oe_n, we_n, sel, sclk, guard;
    logic [7:0] host_bus, v;
    wire [7:0] bus_out;
    wire [7:0] bus_wire;
    wire bus_oe, rb_out, rb_oe, standby, deep;
    int failures = 0;
    int comparisons = 0;
    int n;
    // the device wins the shared bus while it drives; ready/busy has a pull-up
    assign bus_wire = bus_oe ? bus_out : host_bus;
    wire rb_wire = rb_oe ? rb_out : 1'b1;
    flash_host_model i_host (.clk(clock), .cs_n(cs_n), .oe_n(oe_n), .we_n(we_n),
        .sel(sel), .sclk(sclk), .guard(guard), .bus(host_bus));
    sector_flash_host_interface #(.PROG_CYCLES(PROG), .ERASE_CYCLES(ERASE)) i_dut (
        .CLOCK(clock), .SRST(srst), .CHIP_SELECT_N(cs_n), .OUTPUT_ENABLE_N(oe_n),
        .WRITE_STROBE_N(we_n), .COMMAND_DATA_SELECT(sel), .SERIAL_DATA_CLOCK(sclk),
        .POWER_GUARD_HOLD(guard), .BYTE_BUS_IN(bus_wire), .BYTE_BUS_OUT(bus_out),
        .BYTE_BUS_OE(bus_oe), .READY_BUSY_OUT(rb_out), .READY_BUSY_OE(rb_oe),
        .STANDBY(standby), .DEEP_STANDBY(deep));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH t=%0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic status();
        i_host.pins(1'b0, 1'b0, 1'b1);
        repeat (8) @(negedge clock);
        v = bus_out;
        chk(bus_oe, 1'b1);
        i_host.pins(1'b0, 1'b1, 1'b1);
        repeat (8) @(negedge clock);
        chk(bus_oe, 1'b0);
    endtask
    task automatic wait_ready();
        n = 0;
        while (rb_wire !== 1'b1 && n < 500) begin
            @(negedge clock);
            n++;
        end
    endtask
    task automatic t_erase();
        i_host.xfer(2'b00, 8'h20);
        i_host.xfer(2'b01, 8'h12);
        i_host.xfer(2'b01, 8'h03);
        i_host.xfer(2'b00, 8'hB0);
        chk(rb_wire, 1'b0);
        status();
        chk(v[7], 1'b0);
        i_host.pins(1'b1, 1'b1, 1'b1);
        repeat (8) @(negedge clock);
        chk(standby, 1'b0);
        wait_ready();
        chk(n < ERASE, 1'b1);
        repeat (8) @(negedge clock);
        chk(standby, 1'b1);
    endtask
    task automatic t_program();
        logic [7:0] codes [4] = '{8'h10, 8'h1F, 8'h0F, 8'h11};
        foreach (codes[i]) begin
            i_host.xfer(2'b00, codes[i]);
            // an address byte equal to the confirm code must not start the program
            i_host.xfer(2'b01, 8'h40);
            i_host.xfer(2'b01, 8'h00);
            repeat (3) i_host.xfer(2'b10, codes[i] ^ 8'hA5);
            chk(rb_wire, 1'b1);
            i_host.xfer(2'b00, 8'h40);
            chk(rb_wire, 1'b0);
            wait_ready();
            chk(n < PROG, 1'b1);
        end
    endtask
    task automatic t_refuse();
        i_host.xfer(2'b00, 8'h40);
        chk(rb_wire, 1'b1);
        i_host.xfer(2'b00, 8'h20);
        i_host.xfer(2'b00, 8'h12);
        i_host.xfer(2'b00, 8'hB0);
        chk(rb_wire, 1'b1);
        i_host.xfer(2'b00, 8'h50);
        i_host.xfer(2'b00, 8'hFF);
        status();
        chk({v[7], v[5]}, 2'b10);
    endtask
    task automatic t_guard();
        i_host.pins(1'b0, 1'b0, 1'b0);
        repeat (8) @(negedge clock);
        chk({deep, bus_oe}, 2'b10);
        i_host.pins(1'b1, 1'b1, 1'b1);
        repeat (8) @(negedge clock);
        chk(deep, 1'b0);
    endtask
    // command, sector 0312 and column 800 where the validity bytes live
    task automatic cas(input logic [7:0] c);
        i_host.xfer(2'b00, c);
        i_host.xfer(2'b01, 8'h12);
        i_host.xfer(2'b01, 8'h03);
        i_host.xfer(2'b01, 8'h00);
        i_host.xfer(2'b01, 8'h08);
    endtask
    task automatic t_validity();
        logic [7:0] keep [2];
        cas(8'h10);
        i_host.xfer(2'b10, 8'h6B);
        i_host.xfer(2'b10, 8'h94);
        i_host.xfer(2'b00, 8'h40);
        wait_ready();
        chk(n < PROG, 1'b1);
        cas(8'h00);
        i_host.pins(1'b0, 1'b0, 1'b1);
        repeat (8) @(negedge clock);
        keep[0] = bus_out;
        i_host.xfer(2'b10, 8'h00);
        keep[1] = bus_out;
        chk({keep[0], keep[1]}, 16'h6B94);
        i_host.pins(1'b1, 1'b1, 1'b1);
        repeat (8) @(negedge clock);
        chk(standby, 1'b1);
        status();
        chk(v, 8'h80);
        t_erase();
        // the saved validity bytes go back with the next programme of the sector
        cas(8'h10);
        i_host.xfer(2'b10, keep[0]);
        i_host.xfer(2'b10, keep[1]);
        i_host.xfer(2'b00, 8'h40);
        wait_ready();
        chk(n < PROG, 1'b1);
    endtask
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    initial begin
        repeat (5000) @(posedge clock);
        failures++;
        print_verdict();
    end
    initial begin
        srst = 1'b1;
        repeat (4) @(negedge clock);
        i_host.pins(1'b1, 1'b1, 1'b1);
        repeat (16) @(negedge clock);
        srst = 1'b0;
        repeat (4) @(negedge clock);
        chk({bus_oe, rb_oe, standby}, 3'b001);
        status();
        chk({v[7], v[5]}, 2'b10);
        t_validity();
        t_program();
        t_refuse();
        t_guard();
        print_verdict();
    end
endmodule // tb
`default_nettype wire
